// ### trc_regs.svh
// Constants for the readout column: tag widths, reset values, word marks.
// Included by its bare name by the column top and by its testbench.
`ifndef TRC_REGS_SVH
`define TRC_REGS_SVH

// Tag counter widths and reset values
`define TRC_CLK_W 48
`define TRC_EVT_W 16
`define TRC_CLK_RST 48'h0
`define TRC_EVT_RST 16'h0

// Link word marks, in bits 31:28 of every word
`define TRC_HDR_MARK 4'ha
`define TRC_TIME_MARK 4'hb
`define TRC_STAT_MARK 4'hc
`define TRC_DATA_MARK 4'h5

// Status word flag positions
`define TRC_FLAG_OVF 0
`define TRC_FLAG_WARN 1

`endif

// ### trc_pkg.sv
// Types shared by the readout column.
// Assumes nothing of its surroundings.
`default_nettype none
package trc_pkg;

	typedef enum logic [2:0] {
		MRG_IDLE,
		MRG_HDR0,
		MRG_HDR1,
		MRG_HDR2,
		MRG_FETCH,
		MRG_SEND
	} trc_merge_e;

endpackage

`default_nettype wire

// ### trc_fifo_mem.sv
// Derandomizer storage for one channel: one write port, one read port.
// Assumes the owner keeps the pointers; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none

module trc_fifo_mem #(
	parameter int W = 14,
	parameter int AW = 5
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [W-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [W-1:0] rdData
);

	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

`default_nettype wire

// ### trc_readout_column.sv
// Readout column for one crystal: latency pipeline, frame capture, tagging,
// derandomizers, merge, formatting and link output, core event detection.
// Assumes samples, accept and config come from logic on mclk; the link
// partner takes a word when linkValid and linkReady are both high.
// Notes on behaviour
// RULE1 - Every channel's samples pass a delay whose length is a parameter, set per location to decision plus propagation time.
// RULE2 - The accept latency is constant and equals the delay length, so an accept meets its own stored samples.
// RULE3 - The delay is a plain shift pipeline that moves on every clock.
// RULE4 - An accept captures a frame of FRAME consecutive samples per channel, never a single sample.
// RULE5 - Each captured frame is tagged with the current clock count and event number.
// RULE6 - Accepted frames go into a first-in first-out derandomizer that decouples accept rate from readout.
// RULE7 - A merge engine reads one event's data from all channel derandomizers and makes one front-end event.
// RULE8 - Every front-end event carries the clock count, event number and a front-end identifier.
// RULE9 - Every front-end event carries the worst fill level and an almost-full warning.
// RULE10 - Formatted events leave over a valid/ready word link to the event collector driver.
// RULE11 - Core-contact samples feed the trigger primitive builder for event detection.
// RULE12 - A configuration input chooses between a trigger request to the central processor and a local trigger.
// RULE13 - The central timing network handles throttling, fast commands, calibration triggers and dead-time monitoring.
// RULE14 - The clock count is 48 bits and counts elapsed clock cycles.
// RULE15 - The event number is 16 bits and counts accepts received.
// RULE16 - The central timing network supplies the common clock that runs all of this logic.
// RULE17 - An accept that finds the derandomizer full is dropped and sets a sticky overflow flag.
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.svh"

module trc_readout_column #(
	parameter int NCH = 4,
	parameter int DW = 14,
	parameter int LAT = 8,
	parameter int FRAME = 8,
	parameter int TAGAW = 2
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [NCH*DW-1:0] sampleData,
	input wire logic levelOneAccept,
	input wire logic localTriggerMode,
	input wire logic [DW-1:0] coreThreshold,
	input wire logic [11:0] frontEndId,
	input wire logic clearErrors,
	input wire logic linkReady,
	output logic [31:0] linkData,
	output logic linkValid,
	output logic linkLast,
	output logic triggerRequest,
	output logic localTrigger,
	output logic overflowError,
	output logic fillWarning
);

	localparam int SW = $clog2(FRAME);
	localparam int AW = TAGAW + SW;
	localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
	localparam int TW = `TRC_CLK_W + `TRC_EVT_W;

	logic [NCH*DW-1:0] pipe_r [0:LAT-1];
	logic [NCH*DW-1:0] tap;
	logic [`TRC_CLK_W-1:0] clockCount_r;
	logic [`TRC_EVT_W-1:0] eventNum_r;
	logic coreAbove_r;
	logic coreHit;
	logic accept;
	logic acceptTaken;
	logic capturing_r;
	logic [SW-1:0] capIdx_r;
	logic [TAGAW:0] wrFp_r;
	logic [TAGAW:0] rdFp_r;
	logic [TAGAW:0] used;
	logic full;
	logic [TW-1:0] tagMem_r [0:(1<<TAGAW)-1];
	logic [TW-1:0] curTag_r;
	trc_pkg::trc_merge_e state_r;
	logic [SW-1:0] sIdx_r;
	logic [CW-1:0] chIdx_r;
	logic [NCH*DW-1:0] rdData;
	logic [AW-1:0] rdAddr;
	logic outFree;
	logic emit;
	logic [31:0] emitData;
	logic emitLast;
	logic framePop;
	logic [DW-1:0] chSample;

	// Latency pipeline
	assign tap = pipe_r[LAT-1];
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < LAT; i++) begin
				pipe_r[i] <= '0;
			end
		end else begin
			pipe_r[0] <= sampleData; // RULE1 RULE3
			for (int i = 1; i < LAT; i++) begin
				pipe_r[i] <= pipe_r[i-1]; // RULE3
			end
		end
	end

	// Global time tags
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clockCount_r <= `TRC_CLK_RST;
		end else begin
			clockCount_r <= clockCount_r + 48'h1; // RULE14
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			eventNum_r <= `TRC_EVT_RST;
		end else if (accept) begin
			eventNum_r <= eventNum_r + 16'h1; // RULE15
		end
	end

	// Core event detection: rising crossing of the threshold on channel 0
	assign coreHit = (sampleData[DW-1:0] > coreThreshold) && !coreAbove_r;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			coreAbove_r <= 1'b0;
			triggerRequest <= 1'b0;
			localTrigger <= 1'b0;
		end else begin
			coreAbove_r <= sampleData[DW-1:0] > coreThreshold; // RULE11
			triggerRequest <= coreHit && !localTriggerMode; // RULE12
			localTrigger <= coreHit && localTriggerMode; // RULE12
		end
	end

	// Frame capture; accepts during a capture or when full are dropped
	assign accept = levelOneAccept || localTrigger;
	assign used = wrFp_r - rdFp_r;
	assign full = used == (TAGAW+1)'(1 << TAGAW);
	assign acceptTaken = accept && !capturing_r && !full; // RULE17 RULE2

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			capturing_r <= 1'b0;
			capIdx_r <= '0;
			wrFp_r <= '0;
		end else if (acceptTaken) begin
			capturing_r <= 1'b1; // RULE4
			capIdx_r <= '0;
		end else if (capturing_r) begin
			capIdx_r <= capIdx_r + SW'(1);
			if (capIdx_r == SW'(FRAME-1)) begin
				capturing_r <= 1'b0;
				wrFp_r <= wrFp_r + (TAGAW+1)'(1); // RULE6
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (acceptTaken) begin
			tagMem_r[wrFp_r[TAGAW-1:0]] <= {clockCount_r, eventNum_r}; // RULE5
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			overflowError <= 1'b0;
		end else if (accept && !acceptTaken) begin
			overflowError <= 1'b1; // RULE17
		end else if (clearErrors) begin
			overflowError <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fillWarning <= 1'b0;
		end else begin
			fillWarning <= used >= (TAGAW+1)'((1 << TAGAW) - 1); // RULE9
		end
	end

	// One derandomizer per channel, sharing frame pointers
	assign rdAddr = {rdFp_r[TAGAW-1:0], sIdx_r};
	for (genvar c = 0; c < NCH; c++) begin : g_derand
		trc_fifo_mem #(
			.W(DW),
			.AW(AW)
		) u_mem (
			.mclk(mclk),
			.reset_n(reset_n),
			.wrEn(capturing_r),
			.wrAddr({wrFp_r[TAGAW-1:0], capIdx_r}),
			.wrData(tap[c*DW +: DW]),
			.rdAddr(rdAddr),
			.rdData(rdData[c*DW +: DW])
		); // RULE6
	end

	// Merge engine and formatting
	assign outFree = !linkValid || linkReady;
	assign chSample = rdData[chIdx_r*DW +: DW];
	assign framePop = (state_r == trc_pkg::MRG_SEND) && outFree &&
		(chIdx_r == CW'(NCH-1)) && (sIdx_r == SW'(FRAME-1));

	always_comb begin
		emit = 1'b0;
		emitData = 32'h0;
		emitLast = 1'b0;
		case (state_r)
			trc_pkg::MRG_HDR0: begin
				emit = 1'b1;
				emitData = {`TRC_HDR_MARK, frontEndId,
					curTag_r[`TRC_EVT_W-1:0]}; // RULE8
			end
			trc_pkg::MRG_HDR1: begin
				emit = 1'b1;
				emitData = {`TRC_TIME_MARK, curTag_r[TW-1:TW-28]}; // RULE8
			end
			trc_pkg::MRG_HDR2: begin
				emit = 1'b1;
				// Clock low bits, fill level, warning and overflow in 32 bits
				emitData = {`TRC_STAT_MARK, curTag_r[TW-29:`TRC_EVT_W],
					6'(used), fillWarning, overflowError}; // RULE9
			end
			trc_pkg::MRG_SEND: begin
				emit = 1'b1;
				emitData = {`TRC_DATA_MARK, 4'h0, 8'(chIdx_r),
					16'(chSample)}; // RULE7
				emitLast = (chIdx_r == CW'(NCH-1)) && (sIdx_r == SW'(FRAME-1));
			end
			default: begin
				emit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= trc_pkg::MRG_IDLE;
			sIdx_r <= '0;
			chIdx_r <= '0;
			rdFp_r <= '0;
			curTag_r <= '0;
		end else begin
			case (state_r)
				trc_pkg::MRG_IDLE: begin
					if (wrFp_r != rdFp_r) begin
						curTag_r <= tagMem_r[rdFp_r[TAGAW-1:0]]; // RULE7
						state_r <= trc_pkg::MRG_HDR0;
					end
				end
				trc_pkg::MRG_HDR0: begin
					if (outFree) state_r <= trc_pkg::MRG_HDR1;
				end
				trc_pkg::MRG_HDR1: begin
					if (outFree) state_r <= trc_pkg::MRG_HDR2;
				end
				trc_pkg::MRG_HDR2: begin
					if (outFree) begin
						sIdx_r <= '0;
						state_r <= trc_pkg::MRG_FETCH;
					end
				end
				trc_pkg::MRG_FETCH: begin
					chIdx_r <= '0;
					state_r <= trc_pkg::MRG_SEND;
				end
				trc_pkg::MRG_SEND: begin
					if (outFree) begin
						if (chIdx_r != CW'(NCH-1)) begin
							chIdx_r <= chIdx_r + CW'(1);
						end else if (sIdx_r != SW'(FRAME-1)) begin
							sIdx_r <= sIdx_r + SW'(1);
							state_r <= trc_pkg::MRG_FETCH;
						end else begin
							rdFp_r <= rdFp_r + (TAGAW+1)'(1); // RULE6
							state_r <= trc_pkg::MRG_IDLE;
						end
					end
				end
				default: begin
					state_r <= trc_pkg::MRG_IDLE;
				end
			endcase
		end
	end

	// Link output register, held while the driver stalls
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			linkData <= 32'h0;
			linkValid <= 1'b0;
			linkLast <= 1'b0;
		end else if (outFree) begin
			linkValid <= emit; // RULE10
			if (emit) begin
				linkData <= emitData;
				linkLast <= emitLast;
			end
		end
	end

	// Helper: cycles since reset, saturating
	logic [15:0] warm_r;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			warm_r <= 16'h0;
		end else if (warm_r != 16'hffff) begin
			warm_r <= warm_r + 16'h1;
		end
	end

	property p_clock_count;
		@(posedge mclk) disable iff (!reset_n)
		1'b1 |=> clockCount_r == $past(clockCount_r) + 48'h1;
	endproperty
	a_clock_count: assert property (p_clock_count) else $error("clock count did not advance by one"); // RULE14

	property p_event_count;
		@(posedge mclk) disable iff (!reset_n)
		accept |=> eventNum_r == $past(eventNum_r) + 16'h1;
	endproperty
	a_event_count: assert property (p_event_count) else $error("event number missed an accept"); // RULE15

	property p_latency;
		@(posedge mclk) disable iff (!reset_n)
		(warm_r > 16'(LAT)) |-> tap == $past(sampleData, LAT);
	endproperty
	a_latency: assert property (p_latency) else $error("pipeline tap not delayed by the latency"); // RULE2

	property p_overflow;
		@(posedge mclk) disable iff (!reset_n)
		(levelOneAccept && full) |=> overflowError && $stable(wrFp_r);
	endproperty
	a_overflow: assert property (p_overflow) else $error("full accept not flagged or not dropped"); // RULE17

	property p_frame;
		@(posedge mclk) disable iff (!reset_n)
		acceptTaken |=> capturing_r && capIdx_r == '0;
	endproperty
	a_frame: assert property (p_frame) else $error("accepted frame capture did not start"); // RULE4

	property p_frame_end;
		@(posedge mclk) disable iff (!reset_n)
		(capturing_r && capIdx_r == SW'(FRAME-1)) |=>
			!capturing_r && wrFp_r == $past(wrFp_r) + (TAGAW+1)'(1);
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame did not commit after its last sample"); // RULE6

	property p_tag;
		@(posedge mclk) disable iff (!reset_n)
		acceptTaken |=> tagMem_r[$past(wrFp_r[TAGAW-1:0])] ==
			{$past(clockCount_r), $past(eventNum_r)};
	endproperty
	a_tag: assert property (p_tag) else $error("frame tag does not match the time tags"); // RULE5

	property p_core_mode;
		@(posedge mclk) disable iff (!reset_n)
		coreHit |=> (triggerRequest != localTrigger) &&
			(localTrigger == $past(localTriggerMode));
	endproperty
	a_core_mode: assert property (p_core_mode) else $error("core hit routed to the wrong trigger"); // RULE12

	property p_link_hold;
		@(posedge mclk) disable iff (!reset_n)
		(linkValid && !linkReady) |=> linkValid && $stable(linkData) && $stable(linkLast);
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("link word changed while stalled"); // RULE10

	property p_header;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == trc_pkg::MRG_HDR0 && outFree) |=>
			linkValid && linkData[31:28] == `TRC_HDR_MARK &&
			linkData[15:0] == $past(curTag_r[15:0]);
	endproperty
	a_header: assert property (p_header) else $error("event header missing its event number"); // RULE8

endmodule

`default_nettype wire

// ### trc_link_sink.sv
// Link sink standing in for the event collector driver.
// Assumes the bench supplies the stall controls and a random coin bit.
`timescale 1ns/1ps
`default_nettype none

module trc_link_sink (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hold,
	input wire logic slow,
	input wire logic coin,
	output logic linkReady
);
	// Ready moves only after an edge; hold stalls for as long as asked
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			linkReady <= 1'b0;
		end else begin
			linkReady <= !hold && (!slow || coin);
		end
	end
endmodule

`default_nettype wire

// ### tb_trc_readout_column.sv
// Testbench for the readout column: random samples, accepts, link checks.
// Assumes the link sink model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.svh"

module tb_trc_readout_column;
	localparam int NCH = 2;
	localparam int DW = 14;
	localparam int LAT = 4;
	localparam int FRAME = 2;
	logic mclk, reset_n, acc, ltm, clr, hold, slow, coin, coreOn;
	logic linkReady, linkValid, linkLast, trigReq, locTrig, ovf, warn;
	logic [NCH*DW-1:0] smp;
	logic [NCH*DW-1:0] hist [0:4095];
	logic [DW-1:0] thr, coreVal;
	logic [11:0] feId;
	logic [31:0] linkData;
	logic [32:0] expQ [$];
	logic [32:0] mskQ [$];
	logic [15:0] seed, evt;
	int edgeNo, failCount, cmpCount, c0;

	trc_readout_column #(.NCH(NCH), .DW(DW), .LAT(LAT), .FRAME(FRAME),
		.TAGAW(2)) uut (.mclk(mclk), .reset_n(reset_n), .sampleData(smp),
		.levelOneAccept(acc), .localTriggerMode(ltm), .coreThreshold(thr),
		.frontEndId(feId), .clearErrors(clr), .linkReady(linkReady),
		.linkData(linkData), .linkValid(linkValid), .linkLast(linkLast),
		.triggerRequest(trigReq), .localTrigger(locTrig),
		.overflowError(ovf), .fillWarning(warn));

	trc_link_sink sink (.mclk(mclk), .reset_n(reset_n), .hold(hold),
		.slow(slow), .coin(coin), .linkReady(linkReady));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		edgeNo <= reset_n ? edgeNo + 1 : 0;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stopTest;
		$display("compares %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One falling edge: fresh samples, recorded against the coming edge
	task automatic tick(input logic a);
		@(negedge mclk);
		seed = lfsr(seed);
		for (int c = 0; c < NCH; c++) begin
			smp[c*DW +: DW] = DW'(seed >> c);
		end
		if (coreOn) begin
			smp[DW-1:0] = coreVal;
		end
		hist[edgeNo] = smp;
		acc = a;
		clr = 1'b0;
		coin = seed[0];
	endtask

	// Expected words of the event taken at edge t
	task automatic push(input int t);
		logic [47:0] k;
		logic [NCH*DW-1:0] s;
		k = 48'(t);
		expQ.push_back({1'b0, `TRC_HDR_MARK, feId, evt});
		expQ.push_back({1'b0, `TRC_TIME_MARK, k[47:20]});
		expQ.push_back({1'b0, `TRC_STAT_MARK, k[19:0], 8'h0});
		mskQ.push_back('1);
		mskQ.push_back('1);
		mskQ.push_back({1'b1, 32'hffffff00});
		for (int f = 0; f < FRAME; f++) begin
			s = hist[t + 1 + f - LAT];
			for (int c = 0; c < NCH; c++) begin
				expQ.push_back({f == FRAME - 1 && c == NCH - 1, `TRC_DATA_MARK,
					4'h0, 8'(c), 16'(s[c*DW +: DW])});
				mskQ.push_back('1);
			end
		end
		evt++;
	endtask

	task automatic drain;
		int n;
		n = 0;
		while (expQ.size() != 0 && n < 3000) begin
			tick(1'b0);
			n++;
		end
		if (expQ.size() != 0) begin
			failCount++;
			stopTest;
		end
	endtask

	always @(posedge mclk) begin
		if (reset_n && linkValid && linkReady) begin
			if (expQ.size() == 0) begin
				check(64'({1'b1, linkLast, linkData}), 64'h0);
			end else begin
				check(64'({linkLast, linkData} & mskQ[0]), 64'(expQ[0] & mskQ[0]));
				void'(expQ.pop_front());
				void'(mskQ.pop_front());
			end
		end
	end

	initial begin
		reset_n = 1'b0;
		{acc, ltm, clr, hold, slow, coin, coreOn} = '0;
		{smp, coreVal, evt, failCount, cmpCount} = '0;
		thr = 14'h3fff;
		seed = 16'h1fc0;
		feId = 12'h5a3;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		check(64'({linkValid, linkLast, trigReq, locTrig, ovf, warn}), 64'h0);
		reset_n = 1'b1;
		repeat (10) tick(1'b0);
		tick(1'b1);
		push(edgeNo);
		tick(1'b1);
		evt++;
		tick(1'b0);
		tick(1'b0);
		check(64'(ovf), 64'h1);
		clr = 1'b1;
		tick(1'b0);
		tick(1'b0);
		check(64'(ovf), 64'h0);
		drain;
		$display("test basic done");
		hold = 1'b1;
		for (int i = 0; i < 4; i++) begin
			tick(1'b1);
			push(edgeNo);
			repeat (FRAME + 2) tick(1'b0);
		end
		repeat (4) tick(1'b0);
		check(64'(warn), 64'h1);
		tick(1'b1);
		evt++;
		tick(1'b0);
		tick(1'b0);
		check(64'(ovf), 64'h1);
		clr = 1'b1;
		tick(1'b0);
		hold = 1'b0;
		slow = 1'b1;
		drain;
		slow = 1'b0;
		$display("test full done");
		for (int m = 0; m < 2; m++) begin
			coreOn = 1'b1;
			thr = 14'h200;
			coreVal = 14'h200;
			ltm = m[0];
			repeat (3) tick(1'b0);
			check(64'({locTrig, trigReq}), 64'h0);
			coreVal = 14'h201;
			tick(1'b0);
			c0 = edgeNo;
			check(64'({locTrig, trigReq}), 64'h0);
			tick(1'b0);
			check(64'({locTrig, trigReq}), m ? 64'h2 : 64'h1);
			if (m == 1) begin
				push(c0 + 1);
			end
			tick(1'b0);
			check(64'({locTrig, trigReq}), 64'h0);
			coreVal = 14'h0;
			drain;
			coreOn = 1'b0;
			thr = 14'h3fff;
		end
		$display("test core done");
		stopTest;
	end
endmodule

`default_nettype wire
